/* epir_pkg.sv */
package epir_pkg;
  // Register map, word aligned byte addresses
  localparam logic [11:0] EPIR_REQ_CTRL_OFS = 12'h000;
  localparam logic [11:0] EPIR_INT_STAT_OFS = 12'h004;
  localparam logic [11:0] EPIR_INT_MASK_OFS = 12'h008;
  localparam int EPIR_ADDR_W = 12;
  // Field positions of the pin request status and control register
  localparam int EPIR_MODE_BIT = 0;
  localparam int EPIR_IE_BIT = 1;
  localparam int EPIR_ACK_BIT = 2;
  localparam int EPIR_FLAG_BIT = 3;
  localparam int EPIR_PE_BIT = 4;
  localparam int EPIR_EDG_BIT = 5;
  localparam int EPIR_PDD_BIT = 6;
  // Reset values
  localparam logic [7:0] EPIR_CTRL_RST = 8'h00;
  localparam logic [1:0] EPIR_STAT_RST = 2'h0;
  localparam logic [1:0] EPIR_MASK_RST = 2'h0;
  // Event bits of the sticky status register
  localparam int EPIR_EV_SET_BIT = 0;
  localparam int EPIR_EV_ACK_BIT = 1;
  localparam int EPIR_SYNC_STAGES = 2;
  typedef enum logic [1:0] {EPIR_HTRANS_IDLE, EPIR_HTRANS_BUSY, EPIR_HTRANS_NONSEQ, EPIR_HTRANS_SEQ} epir_htrans_t;
endpackage

/* epir_sync.sv */
`timescale 1ns/1ps
// Two flop synchroniser; first stage is read only by the second
module epir_sync
  import epir_pkg::*;
#(
  parameter int STAGES = EPIR_SYNC_STAGES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic d,
  output logic q
);
  logic [STAGES-1:0] sh_q;

  // Shift chain, resets to idle low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q <= '0;
    end else begin
      sh_q <= {sh_q[STAGES-2:0], d};
    end
  end

  assign q = sh_q[STAGES-1];
endmodule

/* epir_detect.sv */
`timescale 1ns/1ps
// Edge and level qualifier for the synchronised pin
module epir_detect
  import epir_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_s,
  input wire logic enable,
  input wire logic polarity,
  input wire logic level_mode,
  output logic event_p,
  output logic asserted
);
  logic prev_q;
  logic act;
  logic act_prev;

  // Previous sample for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin_s;
    end
  end

  // Map pin to active sense: high means asserted for chosen polarity
  assign act = polarity ? pin_s : ~pin_s;
  assign act_prev = polarity ? prev_q : ~prev_q;
  assign asserted = enable & act;
  // Edge always qualifies, level only in edge-and-level mode
  assign event_p = enable & act & (~act_prev | level_mode);
endmodule

/* epir_top.sv */
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Functional notes
// [R1] Bit 6 set disables the pin pull device while the pin function is enabled.
// [R2] Bit 5 selects falling/low events at 0, rising/high events at 1.
// [R3] With pin enabled and rising polarity, the pull becomes a pulldown.
// [R4] Bit 4 enables the pin as an interrupt request input.
// [R5] Read-only flag in bit 3 sets on each qualifying pin event.
// [R6] Writing 1 to bit 2 clears the flag; 0 does nothing; reads zero.
// [R7] In edge-and-level mode acknowledge cannot clear while pin stays asserted.
// [R8] Bit 1 drives an interrupt request while the flag is set.
// [R9] Bit 0 selects edge-only events at 0, edges and levels at 1.
// [R10] Pin is synchronised, edges from successive samples, no events when disabled.
module epir_top
  import epir_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic irq_pin,
  output logic pull_enable,
  output logic pull_down,
  output logic pin_irq_req,
  output logic irq
);
  logic [7:0] ctrl_q;
  logic flag_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [EPIR_ADDR_W-1:0] wr_addr_q;
  logic rd_req;
  logic [EPIR_ADDR_W-1:0] a_addr;
  logic pin_s;
  logic ev;
  logic asserted;
  logic wr_ctrl;
  logic ack_req;
  logic ack_ok;
  logic rd_stat;
  logic pull_device_disable;
  logic edge_polarity_select;
  logic pin_function_enable;
  logic request_interrupt_enable;
  logic detection_mode_select;

  assign pull_device_disable = ctrl_q[EPIR_PDD_BIT];
  assign edge_polarity_select = ctrl_q[EPIR_EDG_BIT];
  assign pin_function_enable = ctrl_q[EPIR_PE_BIT];
  assign request_interrupt_enable = ctrl_q[EPIR_IE_BIT];
  assign detection_mode_select = ctrl_q[EPIR_MODE_BIT];

  // Pin synchroniser
  epir_sync #(.STAGES(EPIR_SYNC_STAGES)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(irq_pin),
    .q(pin_s)
  );

  // Event qualifier, silent while the pin function is off
  epir_detect u_det ( // [R10] [R2] [R9]
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_s(pin_s),
    .enable(pin_function_enable),
    .polarity(edge_polarity_select),
    .level_mode(detection_mode_select),
    .event_p(ev),
    .asserted(asserted)
  );

  // AHB-Lite address phase; zero wait states, always OKAY
  assign a_addr = haddr[EPIR_ADDR_W-1:0];
  assign rd_req = hsel & hready & htrans[1] & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Latch write address so data phase can apply hwdata
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= hsel & hready & htrans[1] & hwrite;
      wr_addr_q <= a_addr;
    end
  end

  assign wr_ctrl = wr_pend_q & (wr_addr_q == EPIR_REQ_CTRL_OFS);
  assign ack_req = wr_ctrl & hwdata[EPIR_ACK_BIT]; // [R6]
  // Level mode holds the flag while the pin stays asserted
  assign ack_ok = ack_req & ~(detection_mode_select & asserted); // [R7]
  assign rd_stat = rd_req & (a_addr == EPIR_INT_STAT_OFS);

  // Control bits; flag and acknowledge are not stored here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= EPIR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q[EPIR_PDD_BIT] <= hwdata[EPIR_PDD_BIT];
      ctrl_q[EPIR_EDG_BIT] <= hwdata[EPIR_EDG_BIT];
      ctrl_q[EPIR_PE_BIT] <= hwdata[EPIR_PE_BIT]; // [R4]
      ctrl_q[EPIR_IE_BIT] <= hwdata[EPIR_IE_BIT];
      ctrl_q[EPIR_MODE_BIT] <= hwdata[EPIR_MODE_BIT];
    end
  end

  // Request flag; a new event wins over an acknowledge in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (ev) begin
      flag_q <= 1'b1; // [R5]
    end else if (ack_ok) begin
      flag_q <= 1'b0; // [R6]
    end
  end

  // Sticky event status, cleared by reading; events win over the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= EPIR_STAT_RST;
    end else begin
      stat_q[EPIR_EV_SET_BIT] <= ev | (stat_q[EPIR_EV_SET_BIT] & ~rd_stat);
      stat_q[EPIR_EV_ACK_BIT] <= ack_ok | (stat_q[EPIR_EV_ACK_BIT] & ~rd_stat);
    end
  end

  // Mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= EPIR_MASK_RST;
    end else if (wr_pend_q && wr_addr_q == EPIR_INT_MASK_OFS) begin
      mask_q <= hwdata[1:0];
    end
  end

  // Read data registered at the address phase; acknowledge bit reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_req) begin
      unique case (a_addr)
        EPIR_REQ_CTRL_OFS: begin
          hrdata_q <= {24'h000000, 1'b0, ctrl_q[EPIR_PDD_BIT:EPIR_PE_BIT], flag_q, 1'b0,
                       ctrl_q[EPIR_IE_BIT:EPIR_MODE_BIT]}; // [R6] [R5]
        end
        EPIR_INT_STAT_OFS: begin
          hrdata_q <= {30'h00000000, stat_q};
        end
        EPIR_INT_MASK_OFS: begin
          hrdata_q <= {30'h00000000, mask_q};
        end
        default: begin
          hrdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  // Pull device, on only while the pin is enabled: pullup for falling polarity, pulldown for rising polarity
  assign pull_enable = pin_function_enable & ~pull_device_disable; // [R1]
  assign pull_down = pin_function_enable & edge_polarity_select; // [R3]
  // CPU request path and system interrupt line
  assign pin_irq_req = request_interrupt_enable & flag_q; // [R8]
  assign irq = |(stat_q & mask_q);

  sequence s_ack_blocked;
    ack_req && detection_mode_select && asserted && !ev;
  endsequence

  a_flag_on_event: assert property (@(posedge hclk) disable iff (!hresetn)
    ev |=> flag_q) else $error("flag not set after event"); // [R5]
  a_ack_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_req && !ev && !(detection_mode_select && asserted) |=> !flag_q) else $error("ack failed"); // [R6]
  a_ack_zero_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && !hwdata[EPIR_ACK_BIT] && flag_q |=> flag_q) else $error("zero ack cleared"); // [R6]
  a_level_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_q ##0 s_ack_blocked |=> flag_q) else $error("level ack cleared"); // [R7]
  a_req_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_irq_req == (flag_q && request_interrupt_enable)) else $error("req mismatch"); // [R8]
  a_no_ev_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !pin_function_enable |-> !ev) else $error("event while disabled"); // [R10] [R4]
  a_pull_off: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_function_enable && pull_device_disable |-> !pull_enable) else $error("pull not off"); // [R1]
  a_pulldown_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    pull_down |-> pin_function_enable && edge_polarity_select) else $error("pulldown wrong"); // [R3]
  a_edge_only: assert property (@(posedge hclk) disable iff (!hresetn)
    !detection_mode_select && $past(asserted) && asserted && $stable(pin_function_enable)
    && $stable(edge_polarity_select) |-> !ev) else $error("level event in edge mode"); // [R9] [R2]
endmodule

/* epir_pin_model.sv */
`timescale 1ns/1ps
// Outside circuit on the request pin: a driver that can let go of the line
module epir_pin_model (
  input wire logic hclk,
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic pull_enable,
  input wire logic pull_down,
  output logic irq_pin
);
  logic float_q;
  // A line with no driver and no pull wanders, so it never holds the last value
  always_ff @(posedge hclk) begin
    float_q <= ~irq_pin;
  end
  // Released line follows the pull: low for a pulldown, high for a pullup
  assign irq_pin = drive_en ? drive_val : (pull_enable ? ~pull_down : float_q);
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// Register-level tests of the pin request block
module testbench;
  import epir_pkg::*;
  localparam logic [31:0] CA = {20'h00000, EPIR_REQ_CTRL_OFS};
  localparam logic [31:0] SA = {20'h00000, EPIR_INT_STAT_OFS};
  localparam logic [31:0] MA = {20'h00000, EPIR_INT_MASK_OFS};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = EPIR_HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic drv_en = 1'b1;
  logic drv_val = 1'b1;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, irq_pin, pull_enable, pull_down, pin_irq_req, irq;
  int num_errors = 0;
  int total_checks = 0;
  // 40 MHz bus clock
  always #12.5 hclk = ~hclk;
  epir_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_pin(irq_pin), .pull_enable(pull_enable),
    .pull_down(pull_down), .pin_irq_req(pin_irq_req), .irq(irq));
  epir_pin_model i_pin (.hclk(hclk), .drive_en(drv_en), .drive_val(drv_val),
    .pull_enable(pull_enable), .pull_down(pull_down), .irq_pin(irq_pin));
  // One single-word transfer; the address phase is held until hready is seen
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= EPIR_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= EPIR_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // Let the write settle so outputs are not sampled at their launching edge
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask
  // Pin change, then the fixed three-edge path to the flag plus margin
  task automatic pin(input logic v);
    @(posedge hclk);
    drv_val <= v;
    repeat (4) @(posedge hclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Tests take about 160 cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(CA, 32'h00000000);
    rdchk(SA, 32'h00000000);
    rdchk(MA, 32'h00000000);
    rdchk(32'h0000000C, 32'h00000000);
    chk({31'h0, pull_enable}, 32'h00000000);
    $display("test reset done");
    xfer(1'b1, CA, 32'h00000010);
    chk({30'h0, pull_enable, pull_down}, 32'h00000002);
    xfer(1'b1, CA, 32'h00000030);
    chk({30'h0, pull_enable, pull_down}, 32'h00000003);
    xfer(1'b1, CA, 32'h00000070);
    chk({31'h0, pull_enable}, 32'h00000000);
    $display("test pull done");
    xfer(1'b1, CA, 32'h00000010);
    pin(1'b0);
    rdchk(CA, 32'h00000018);
    xfer(1'b1, CA, 32'h00000010);
    rdchk(CA, 32'h00000018);
    xfer(1'b1, CA, 32'h00000014);
    rdchk(CA, 32'h00000010);
    pin(1'b1);
    $display("test edge done");
    xfer(1'b1, CA, 32'h00000011);
    pin(1'b0);
    xfer(1'b1, CA, 32'h00000015);
    rdchk(CA, 32'h00000019);
    pin(1'b1);
    xfer(1'b1, CA, 32'h00000015);
    rdchk(CA, 32'h00000011);
    $display("test level done");
    xfer(1'b1, CA, 32'h00000000);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    rdchk(CA, 32'h00000000);
    xfer(1'b1, CA, 32'h00000030);
    pin(1'b1);
    rdchk(CA, 32'h00000038);
    xfer(1'b1, CA, 32'h00000036);
    rdchk(CA, 32'h00000032);
    chk({31'h0, pin_irq_req}, 32'h00000000);
    $display("test rising done");
    xfer(1'b1, SA, 32'h00000000);
    xfer(1'b1, MA, 32'h00000001);
    pin(1'b0);
    pin(1'b1);
    chk({30'h0, pin_irq_req, irq}, 32'h00000003);
    xfer(1'b1, CA, 32'h00000030);
    chk({31'h0, pin_irq_req}, 32'h00000000);
    rdchk(CA, 32'h00000038);
    rdchk(SA, 32'h00000003);
    chk({31'h0, irq}, 32'h00000000);
    xfer(1'b1, CA, 32'h00000034);
    chk({31'h0, irq}, 32'h00000000);
    xfer(1'b1, MA, 32'h00000002);
    chk({31'h0, irq}, 32'h00000001);
    rdchk(SA, 32'h00000002);
    chk({31'h0, irq}, 32'h00000000);
    $display("test interrupt done");
    close_out();
  end
endmodule
